// file: sfp_defines.vh
/*
 Shared constants of the serial flash front end: opcodes, status
 layout, register map, erase geometry, reset values and timing.
 Assumes a core clock of 200 MHz and a 4 MByte array.
*/
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH

// Opcodes
`define SFP_OP_READ 8'h03
`define SFP_OP_FAST_READ 8'h0b
`define SFP_OP_BYTE_PROG 8'h02
`define SFP_OP_WORD_PROG 8'had
`define SFP_OP_SECTOR_ERASE 8'h20
`define SFP_OP_BLOCK32_ERASE 8'h52
`define SFP_OP_BLOCK64_ERASE 8'hd8
`define SFP_OP_STATUS_READ 8'h05
`define SFP_OP_LATCH_SET 8'h06
`define SFP_OP_LATCH_CLEAR 8'h04
`define SFP_OP_BUSY_OUT_EN 8'h70
`define SFP_OP_BUSY_OUT_DIS 8'h80
`define SFP_OP_ID_READ 8'h90
`define SFP_OP_ID_READ_ALT 8'hab

// Status byte field positions
`define SFP_ST_BUSY 0
`define SFP_ST_LATCH 1
`define SFP_ST_PROT_LSB 2
`define SFP_ST_WORD_MODE 6

// Register map (byte addresses)
`define SFP_REG_CTRL 12'h000
`define SFP_REG_STATUS 12'h004
`define SFP_REG_ADDR 12'h008
`define SFP_CTRL_PROT_RST 3'h7

// Erase geometry
`define SFP_SECTOR_LSB 12
`define SFP_BLOCK32_LSB 15
`define SFP_BLOCK64_LSB 16
`define SFP_ERASED_BYTE 8'hff

// Timing
`define SFP_CLK_MHZ 200
`define SFP_PROG_TIME_US 10
`define SFP_ERASE_TIME_US 25000
`define SFP_PROG_CYCLES (`SFP_PROG_TIME_US * `SFP_CLK_MHZ)
`define SFP_ERASE_CYCLES (`SFP_ERASE_TIME_US * `SFP_CLK_MHZ)

`endif

// file: sfp_sync.v
/*
 Two flip-flop synchroniser, one per bit.
 Assumes inputs are asynchronous levels; resets to RST_VAL.
*/
`timescale 1ns/1ps
module sfp_sync #(
	parameter W = 3,
	parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			reg meta;
			reg stable;
			always @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta <= RST_VAL[g];
					stable <= RST_VAL[g];
				end else begin
					meta <= d_i[g];
					stable <= meta;
				end
			end
			assign q_o[g] = stable;
		end
	endgenerate
endmodule // sfp_sync

// file: sfp_array.v
/*
 Byte array of the flash: one write port, one registered read port.
 Assumes the caller holds write address and data for the write cycle.
*/
`timescale 1ns/1ps
module sfp_array #(
	parameter ADDR_W = 22
) (
	input wire clk_i,
	input wire we_i,
	input wire [ADDR_W-1:0] waddr_i,
	input wire [7:0] wdata_i,
	input wire [ADDR_W-1:0] raddr_i,
	output reg [7:0] rdata_o
);
	reg [7:0] mem [0:(1<<ADDR_W)-1];

	always @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule // sfp_array

// file: sfp_core.v
/*
 Serial flash command front end with APB control port.
 Assumes SPI mode 0 or 3 at most 1/8 of the core clock; pins are async.
*/
//
// Summary of operation
// - Opcode 03H plus three address bytes starts a normal read, clock up to 25 MHz.
// - Read address increments per byte and wraps from top to zero.
// - Read data streams until select rises.
// - Opcode 0BH takes address and one dummy byte before data.
// - Opcode 02H takes address then one data byte, MSB first.
// - Program or erase aimed at a protected region is ignored.
// - Self-timed program or erase starts when select rises.
// - First ADH takes address then two bytes: even then odd address.
// - Later ADH takes only two bytes for the next two addresses.
// - In word mode only ADH, 04H, and 05H in software mode, are accepted.
// - Word programming never wraps past the top address.
// - 04H clears latch and word mode, which ends pin mode; the busy output enable stays set until 80H.
// - 70H turns serial output into a busy pin for word mode.
// - Pin mode: select low drives output, 0 busy, 1 ready.
// - 20H erases the 4 KByte sector chosen by bits 12 upward.
// - 32 KByte block uses bits 15 up, 64 KByte bits 16 up.
// - Address bits above the top implemented bit are ignored.
// - Every opcode, address or data field is eight clocks long.
// - Status read repeats the status byte until select rises.
// - ID read: address bit 0 picks maker or part code, streamed.
// - Input sampled on rising serial clock, MSB first; select fall starts.
// - Select rising mid-field abandons the command.
// - 52H erases a 32 KByte block, D8H a 64 KByte block.
`timescale 1ns/1ps
`include "sfp_defines.vh"
module sfp_core #(
	parameter ADDR_W = 22,
	parameter PROG_CYCLES = `SFP_PROG_CYCLES,
	parameter ERASE_CYCLES = `SFP_ERASE_CYCLES,
	parameter [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
	parameter [7:0] PART_CODE = 8'ha5 // Arbitrary value
) (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	input wire cs_n_i,
	input wire sck_i,
	input wire si_i,
	output reg so_o,
	output reg so_oe_o
);
	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_CMD = 7'h02;
	localparam [6:0] ST_ADDR = 7'h04;
	localparam [6:0] ST_DUMMY = 7'h08;
	localparam [6:0] ST_DIN = 7'h10;
	localparam [6:0] ST_OUT = 7'h20;
	localparam [6:0] ST_TAIL = 7'h40;
	localparam [2:0] E_IDLE = 3'h1;
	localparam [2:0] E_WR = 3'h2;
	localparam [2:0] E_WAIT = 3'h4;

	wire [2:0] pins_s;
	wire cs_s;
	wire sck_s;
	wire si_s;
	reg cs_d;
	reg sck_d;
	reg [6:0] state;
	reg [2:0] bit_cnt;
	reg [6:0] shreg;
	reg [7:0] opcode;
	reg [1:0] byte_cnt;
	reg [23:0] addr;
	reg [7:0] dat0;
	reg [7:0] dat1;
	reg cmd_done;
	reg [1:0] src;
	reg [7:0] obyte;
	reg [2:0] obit;
	reg id_sel;
	reg [ADDR_W-1:0] raddr;
	reg latch;
	reg word_mode;
	reg busy_out_en;
	reg [ADDR_W-1:0] word_addr;
	reg [2:0] prot;
	reg go;
	reg go_erase;
	reg [ADDR_W-1:0] go_base;
	reg [16:0] go_len;
	reg [7:0] go_d0;
	reg [7:0] go_d1;
	reg [2:0] eng;
	reg [ADDR_W-1:0] waddr;
	reg [16:0] left;
	reg [31:0] timer;
	reg op_erase;
	reg [7:0] d0;
	reg [7:0] d1;
	wire [7:0] rdata;
	wire busy;
	wire [7:0] status;
	wire [7:0] in_byte;
	wire byte_done;
	wire cs_fall;
	wire cs_rise;
	wire sck_rise;
	wire sck_fall;
	wire pin_mode;
	wire [7:0] src_byte;
	wire [23:0] addr_in;
	wire [ADDR_W-1:0] full_addr;
	wire [ADDR_W:0] word_next;
	wire [7:0] wdata;
	wire mem_we;
	wire apb_wr;
	wire apb_hit;

	// Pins are async to the core clock
	sfp_sync #(.W(3), .RST_VAL(3'h7)) u_sync (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i({cs_n_i, sck_i, si_i}),
		.q_o(pins_s)
	);
	assign cs_s = pins_s[2];
	assign sck_s = pins_s[1];
	assign si_s = pins_s[0];

	sfp_array #(.ADDR_W(ADDR_W)) u_array (
		.clk_i(ref_clk_i),
		.we_i(mem_we),
		.waddr_i(waddr),
		.wdata_i(wdata),
		.raddr_i(raddr),
		.rdata_o(rdata)
	);

	assign cs_fall = cs_d & ~cs_s;
	assign cs_rise = ~cs_d & cs_s;
	assign sck_rise = ~sck_d & sck_s & ~cs_s;
	assign sck_fall = sck_d & ~sck_s & ~cs_s;
	assign in_byte = {shreg, si_s};
	assign byte_done = sck_rise && (bit_cnt == 3'h7);
	assign addr_in = {addr[15:0], in_byte};
	assign full_addr = addr_in[ADDR_W-1:0];
	// carry out means past the top
	assign word_next = {1'b0, word_addr} + {{(ADDR_W-1){1'b0}}, 2'h2};
	assign pin_mode = busy_out_en && word_mode;

	assign busy = ~eng[0];
	assign status = ({7'h00, busy} << `SFP_ST_BUSY) | ({7'h00, latch} << `SFP_ST_LATCH)
		| ({5'h00, prot} << `SFP_ST_PROT_LSB) | ({7'h00, word_mode} << `SFP_ST_WORD_MODE);
	assign src_byte = (src == 2'h0) ? rdata : (src == 2'h1) ? status
		: (id_sel ? PART_CODE : MAKER_CODE);

	// Protection covers the top 1/2^(7-level) of the array, none at level 0
	function is_prot;
		input [ADDR_W-1:0] a;
		input [2:0] lvl;
		reg [ADDR_W-1:0] low;
		begin
			low = {ADDR_W{1'b1}} >> (3'h7 - lvl);
			if (lvl == 3'h0) begin
				is_prot = 1'b0;
			end else if (lvl == 3'h7) begin
				is_prot = 1'b1;
			end else begin
				is_prot = &(a | low);
			end
		end
	endfunction

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_d <= 1'b1;
			sck_d <= 1'b1;
			state <= ST_IDLE;
			bit_cnt <= 3'h0;
			shreg <= 7'h00;
			opcode <= 8'h00;
			byte_cnt <= 2'h0;
			addr <= 24'h000000;
			dat0 <= 8'h00;
			dat1 <= 8'h00;
			cmd_done <= 1'b0;
			src <= 2'h0;
			obyte <= 8'h00;
			obit <= 3'h0;
			id_sel <= 1'b0;
			raddr <= {ADDR_W{1'b0}};
			latch <= 1'b0;
			word_mode <= 1'b0;
			busy_out_en <= 1'b0;
			word_addr <= {ADDR_W{1'b0}};
			go <= 1'b0;
			go_erase <= 1'b0;
			go_base <= {ADDR_W{1'b0}};
			go_len <= 17'h00000;
			go_d0 <= 8'h00;
			go_d1 <= 8'h00;
			so_o <= 1'b0;
			so_oe_o <= 1'b0;
		end else begin
			cs_d <= cs_s;
			sck_d <= sck_s;
			go <= 1'b0;
			// output enabled only while select low
			so_oe_o <= ~cs_s && ((state == ST_OUT) || pin_mode);
			if (~cs_s && pin_mode && (state != ST_OUT)) begin
				so_o <= ~busy;
			end
			if (cs_fall) begin
				state <= ST_CMD;
				bit_cnt <= 3'h0;
				cmd_done <= 1'b0;
				obit <= 3'h0;
			end else if (cs_rise) begin
				state <= ST_IDLE;
				if (cmd_done && (state == ST_TAIL)) begin
					case (opcode)
						`SFP_OP_LATCH_SET: begin
							latch <= 1'b1;
						end
						`SFP_OP_LATCH_CLEAR: begin
							latch <= 1'b0;
							word_mode <= 1'b0;
						end
						`SFP_OP_BUSY_OUT_EN: begin
							busy_out_en <= 1'b1;
						end
						`SFP_OP_BUSY_OUT_DIS: begin
							busy_out_en <= 1'b0;
						end
						`SFP_OP_BYTE_PROG: begin
							if (latch && !is_prot(addr[ADDR_W-1:0], prot)) begin
								go <= 1'b1;
								go_erase <= 1'b0;
								go_base <= addr[ADDR_W-1:0];
								go_len <= 17'h00001;
								go_d0 <= dat0;
								go_d1 <= dat0;
								latch <= 1'b0;
							end
						end
						`SFP_OP_WORD_PROG: begin
							if (!word_mode) begin
								if (latch && !is_prot({addr[ADDR_W-1:1], 1'b0}, prot)) begin
									go <= 1'b1;
									go_erase <= 1'b0;
									go_base <= {addr[ADDR_W-1:1], 1'b0};
									go_len <= 17'h00002;
									go_d0 <= dat0;
									go_d1 <= dat1;
									word_mode <= 1'b1;
									word_addr <= {addr[ADDR_W-1:1], 1'b0};
								end
							end else if (latch && !word_next[ADDR_W]
								&& !is_prot(word_next[ADDR_W-1:0], prot)) begin
								go <= 1'b1;
								go_erase <= 1'b0;
								go_base <= word_next[ADDR_W-1:0];
								go_len <= 17'h00002;
								go_d0 <= dat0;
								go_d1 <= dat1;
								word_addr <= word_next[ADDR_W-1:0];
							end
						end
						`SFP_OP_SECTOR_ERASE, `SFP_OP_BLOCK32_ERASE, `SFP_OP_BLOCK64_ERASE: begin
							if (latch && !is_prot(go_base, prot)) begin
								go <= 1'b1;
								go_erase <= 1'b1;
								latch <= 1'b0;
							end
						end
						default: begin
							latch <= latch;
						end
					endcase
				end
			end else begin
				if (sck_rise) begin
					shreg <= in_byte[6:0];
					bit_cnt <= bit_cnt + 3'h1;
				end
				if (byte_done) begin
					case (state)
						ST_CMD: begin
							opcode <= in_byte;
							byte_cnt <= 2'h0;
							state <= ST_TAIL;
							if (busy && in_byte != `SFP_OP_STATUS_READ) begin
								state <= ST_TAIL;
							end else if (word_mode && !(in_byte == `SFP_OP_WORD_PROG
								|| in_byte == `SFP_OP_LATCH_CLEAR
								|| (in_byte == `SFP_OP_STATUS_READ && !busy_out_en))) begin
								state <= ST_TAIL;
							end else begin
								case (in_byte)
									`SFP_OP_READ, `SFP_OP_FAST_READ, `SFP_OP_BYTE_PROG,
									`SFP_OP_SECTOR_ERASE, `SFP_OP_BLOCK32_ERASE,
									`SFP_OP_BLOCK64_ERASE, `SFP_OP_ID_READ,
									`SFP_OP_ID_READ_ALT: begin
										state <= ST_ADDR;
									end
									`SFP_OP_WORD_PROG: begin
										state <= word_mode ? ST_DIN : ST_ADDR;
									end
									`SFP_OP_STATUS_READ: begin
										state <= ST_OUT;
										src <= 2'h1;
									end
									`SFP_OP_LATCH_SET, `SFP_OP_LATCH_CLEAR,
									`SFP_OP_BUSY_OUT_EN, `SFP_OP_BUSY_OUT_DIS: begin
										cmd_done <= 1'b1;
									end
									default: begin
										state <= ST_TAIL;
									end
								endcase
							end
						end
						ST_ADDR: begin
							addr <= {addr[15:0], in_byte};
							byte_cnt <= byte_cnt + 2'h1;
							if (byte_cnt == 2'h2) begin
								raddr <= full_addr;
								id_sel <= in_byte[0];
								byte_cnt <= 2'h0;
								case (opcode)
									`SFP_OP_READ: begin
										state <= ST_OUT;
										src <= 2'h0;
									end
									`SFP_OP_FAST_READ: begin
										state <= ST_DUMMY;
										src <= 2'h0;
									end
									`SFP_OP_ID_READ, `SFP_OP_ID_READ_ALT: begin
										state <= ST_OUT;
										src <= 2'h2;
									end
									`SFP_OP_SECTOR_ERASE: begin
										go_base <= full_addr & ({ADDR_W{1'b1}} << `SFP_SECTOR_LSB);
										go_len <= 17'h1 << `SFP_SECTOR_LSB;
										cmd_done <= 1'b1;
										state <= ST_TAIL;
									end
									`SFP_OP_BLOCK32_ERASE: begin
										go_base <= full_addr & ({ADDR_W{1'b1}} << `SFP_BLOCK32_LSB);
										go_len <= 17'h1 << `SFP_BLOCK32_LSB;
										cmd_done <= 1'b1;
										state <= ST_TAIL;
									end
									`SFP_OP_BLOCK64_ERASE: begin
										go_base <= full_addr & ({ADDR_W{1'b1}} << `SFP_BLOCK64_LSB);
										go_len <= 17'h1 << `SFP_BLOCK64_LSB;
										cmd_done <= 1'b1;
										state <= ST_TAIL;
									end
									default: begin
										state <= ST_DIN;
									end
								endcase
							end
						end
						ST_DUMMY: begin
							state <= ST_OUT;
						end
						ST_DIN: begin
							if (byte_cnt == 2'h0) begin
								dat0 <= in_byte;
								byte_cnt <= 2'h1;
								if (opcode == `SFP_OP_BYTE_PROG) begin
									cmd_done <= 1'b1;
									state <= ST_TAIL;
								end
							end else begin
								dat1 <= in_byte;
								cmd_done <= 1'b1;
								state <= ST_TAIL;
							end
						end
						default: begin
							// Extra bytes after a complete command are ignored
							state <= state;
						end
					endcase
				end
				if (sck_fall && (state == ST_OUT)) begin
					obit <= obit + 3'h1;
					if (obit == 3'h0) begin
						so_o <= src_byte[7];
						obyte <= src_byte;
						raddr <= raddr + {{(ADDR_W-1){1'b0}}, 1'b1};
						id_sel <= ~id_sel;
					end else begin
						so_o <= obyte[3'h7 - obit];
					end
				end
			end
		end
	end

	// Self-timed engine: write bytes one per cycle, then hold the time
	assign mem_we = eng[1];
	assign wdata = op_erase ? `SFP_ERASED_BYTE : (waddr[0] ? d1 : d0);

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eng <= E_IDLE;
			waddr <= {ADDR_W{1'b0}};
			left <= 17'h00000;
			timer <= 32'h00000000;
			op_erase <= 1'b0;
			d0 <= 8'h00;
			d1 <= 8'h00;
		end else begin
			case (eng)
				E_IDLE: begin
					if (go) begin
						eng <= E_WR;
						waddr <= go_base;
						left <= go_len;
						op_erase <= go_erase;
						d0 <= go_d0;
						d1 <= go_d1;
					end
				end
				E_WR: begin
					waddr <= waddr + {{(ADDR_W-1){1'b0}}, 1'b1};
					left <= left - 17'h1;
					if (left == 17'h1) begin
						eng <= E_WAIT;
						timer <= op_erase ? ERASE_CYCLES : PROG_CYCLES;
					end
				end
				E_WAIT: begin
					timer <= timer - 32'h1;
					if (timer <= 32'h1) begin
						eng <= E_IDLE;
					end
				end
				default: begin
					eng <= E_IDLE;
				end
			endcase
		end
	end

	// APB slave, zero wait states
	assign pready_o = 1'b1;
	assign apb_hit = (paddr_i == `SFP_REG_CTRL) || (paddr_i == `SFP_REG_STATUS)
		|| (paddr_i == `SFP_REG_ADDR);
	assign pslverr_o = psel_i && penable_i && !apb_hit;
	assign apb_wr = psel_i && penable_i && pwrite_i && (paddr_i == `SFP_REG_CTRL);

	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prot <= `SFP_CTRL_PROT_RST;
			prdata_o <= 32'h00000000;
		end else begin
			if (apb_wr) begin
				prot <= pwdata_i[2:0];
			end
			if (psel_i && !penable_i) begin
				case (paddr_i)
					`SFP_REG_CTRL: prdata_o <= {29'h0, prot};
					`SFP_REG_STATUS: prdata_o <= {24'h0, status};
					`SFP_REG_ADDR: prdata_o <= {{(32-ADDR_W){1'b0}}, raddr};
					default: prdata_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // sfp_core

// file: sfp_core_props.sv
/* Port assertions for the serial flash front end.
 Assumes the core clock and reset of sfp_core; bound at the foot. */
`timescale 1ns/1ps
module sfp_core_props (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	input wire cs_n_i,
	input wire sck_i,
	input wire so_o,
	input wire so_oe_o
);
	logic [3:0] cs_hi;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Saturating idle count; avoids a long repetition
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_hi <= 4'h0;
		end else if (!cs_n_i) begin
			cs_hi <= 4'h0;
		end else if (cs_hi != 4'hf) begin
			cs_hi <= cs_hi + 4'h1;
		end
	end
	a_oe_release: assert property ($rose(cs_n_i) |-> ##[1:6] !so_oe_o)
		else $error("output driven after deselect");
	a_oe_idle: assert property (so_oe_o |-> cs_hi < 4'h8)
		else $error("output driven while idle");
	a_oe_start: assert property ($rose(so_oe_o) |-> !$past(cs_n_i, 2))
		else $error("output enabled without select");
	a_bit_hold: assert property ((sck_i && so_oe_o) [*6] |-> $stable(so_o))
		else $error("output bit moved with clock high");
	a_ready_const: assert property (pready_o)
		else $error("bus not ready");
	a_err_unmapped: assert property (psel_i && penable_i && paddr_i == 12'h00c |-> pslverr_o)
		else $error("unmapped access accepted");
	a_err_phase: assert property (pslverr_o |-> psel_i && penable_i)
		else $error("error outside access");
	a_err_rdzero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
		else $error("refused read gave data");
	a_rdata_hold: assert property (psel_i && penable_i ##1 !psel_i |-> $stable(prdata_o))
		else $error("read data moved after access");
endmodule // sfp_core_props

bind sfp_core sfp_core_props props_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cs_n_i(cs_n_i),
	.sck_i(sck_i), .so_o(so_o), .so_oe_o(so_oe_o));

// file: sfp_host_model.sv
/* Behavioural host SPI controller, mode 0.
 Assumes the bench calls start, xfer and stop in order. */
`timescale 1ns/1ps
module sfp_host_model (
	output logic cs_n_o,
	output logic sck_o,
	output logic si_o,
	input wire so_i,
	input wire so_oe_i
);
	localparam real HALF = 80.0;
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
	end
	task automatic start();
		#1.3;
		cs_n_o = 1'b0;
	endtask
	task automatic xfer(input int n, input logic [7:0] d, output logic [7:0] q);
		q = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			si_o = d[i];
			#(HALF);
			sck_o = 1'b1;
			q = {q[6:0], so_oe_i ? so_i : 1'bx};
			#(HALF);
			sck_o = 1'b0;
		end
	endtask
	// Released data line must not look valid
	task automatic stop();
		#(HALF);
		cs_n_o = 1'b1;
		si_o = ~si_o;
		#(HALF);
	endtask
endmodule // sfp_host_model

// file: tb_top.sv
/* Self-checking bench for sfp_core: APB master and SPI scenarios.
 Assumes sfp_host_model on the serial pins and the bound checker. */
`timescale 1ns/1ps
`include "sfp_defines.vh"
module tb_top;
	localparam [7:0] MAKER = 8'h3e; // Arbitrary value
	localparam [7:0] PART = 8'hc1; // Arbitrary value
	logic ref_clk_i;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rq;
	logic re;
	logic [7:0] sb, fst;
	wire [31:0] prdata;
	wire pready, pslverr, cs_n, sck, si, so, so_oe;
	int n_fail = 0;
	int total_checks = 0;
	// Short counts keep program and erase brief
	sfp_core #(.ADDR_W(17), .PROG_CYCLES(60), .ERASE_CYCLES(50), .MAKER_CODE(MAKER),
		.PART_CODE(PART)) dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cs_n_i(cs_n),
		.sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe));
	sfp_host_model h (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so), .so_oe_i(so_oe));
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk(32'(pready), 32'h1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmd(input logic [7:0] op, input int na, input logic [23:0] a);
		h.start();
		h.xfer(8, op, sb);
		for (int i = 2; i > 2 - na; i--) begin
			h.xfer(8, a[i*8+:8], sb);
		end
	endtask
	task automatic sc(input logic [7:0] op);
		cmd(op, 0, 24'h0);
		h.stop();
	endtask
	task automatic rdchk(input logic [7:0] e);
		h.xfer(8, 8'h00, sb);
		chk(32'(sb), 32'(e));
	endtask
	// Bounded status poll; first byte kept for callers
	task automatic poll();
		int n;
		n = 0;
		cmd(8'h05, 0, 24'h0);
		h.xfer(8, 8'h00, fst);
		sb = fst;
		while (sb[0] !== 1'b0 && n < 160) begin
			h.xfer(8, 8'h00, sb);
			n++;
		end
		h.stop();
		chk(32'(sb[0]), 32'h0);
	endtask
	task automatic t_regs();
		apb(1'b0, `SFP_REG_CTRL, 32'h0);
		chk(rq, 32'h7);
		apb(1'b1, `SFP_REG_STATUS, 32'h0);
		apb(1'b0, `SFP_REG_STATUS, 32'h0);
		chk(rq, 32'h1c);
		apb(1'b0, 12'h00c, 32'h0);
		chk(32'(re), 32'h1);
		chk(rq, 32'h0);
		apb(1'b1, `SFP_REG_CTRL, 32'h0);
		$display("t_regs done");
	endtask
	task automatic t_erase();
		sc(8'h06);
		cmd(8'h05, 0, 24'h0);
		rdchk(8'h02);
		h.stop();
		cmd(8'h20, 3, 24'hfe0abc);
		h.stop();
		poll();
		chk(32'(fst[1:0]), 32'h1);
		sc(8'h06);
		cmd(8'h20, 3, 24'h01f123);
		h.stop();
		poll();
		$display("t_erase done");
	endtask
	task automatic t_prog();
		sc(8'h06);
		cmd(8'h02, 3, 24'h000000);
		h.xfer(8, 8'h5c, sb);
		h.stop();
		apb(1'b0, `SFP_REG_STATUS, 32'h0);
		chk(rq, 32'h1);
		poll();
		cmd(8'h03, 3, 24'h03ffff);
		rdchk(8'hff);
		rdchk(8'h5c);
		rdchk(8'hff);
		h.stop();
		$display("t_prog done");
	endtask
	task automatic t_word();
		sc(8'h06);
		cmd(8'had, 3, 24'h000011);
		h.xfer(8, 8'ha1, sb);
		h.xfer(8, 8'hb2, sb);
		h.stop();
		poll();
		chk(32'(fst[7:1]), 32'h21);
		cmd(8'had, 0, 24'h0);
		h.xfer(8, 8'hc3, sb);
		h.xfer(8, 8'hd4, sb);
		h.stop();
		poll();
		cmd(8'h02, 3, 24'h000014);
		h.xfer(8, 8'h00, sb);
		h.stop();
		sc(8'h04);
		cmd(8'h05, 0, 24'h0);
		rdchk(8'h00);
		rdchk(8'h00);
		h.stop();
		cmd(8'h0b, 3, 24'h00000f);
		h.xfer(8, 8'h00, sb);
		rdchk(8'hff);
		rdchk(8'ha1);
		rdchk(8'hb2);
		rdchk(8'hc3);
		rdchk(8'hd4);
		rdchk(8'hff);
		h.stop();
		sc(8'h06);
		cmd(8'had, 3, 24'h01fffe);
		h.xfer(8, 8'he1, sb);
		h.xfer(8, 8'he2, sb);
		h.stop();
		poll();
		cmd(8'had, 0, 24'h0);
		h.xfer(8, 8'h33, sb);
		h.xfer(8, 8'h44, sb);
		h.stop();
		cmd(8'h05, 0, 24'h0);
		rdchk(8'h42);
		h.stop();
		sc(8'h04);
		cmd(8'h03, 3, 24'h01fffe);
		rdchk(8'he1);
		rdchk(8'he2);
		rdchk(8'h5c);
		h.stop();
		$display("t_word done");
	endtask
	task automatic t_pin();
		int n;
		n = 0;
		sc(8'h70);
		sc(8'h06);
		cmd(8'had, 3, 24'h000030);
		h.xfer(8, 8'h11, sb);
		h.xfer(8, 8'h22, sb);
		h.stop();
		h.start();
		repeat (8) @(negedge ref_clk_i);
		chk(32'({so_oe, so}), 32'h2);
		while (so !== 1'b1 && n < 200) begin
			@(negedge ref_clk_i);
			n++;
		end
		chk(32'(so), 32'h1);
		h.stop();
		chk(32'(so_oe), 32'h0);
		sc(8'h04);
		sc(8'h80);
		cmd(8'h03, 3, 24'h000030);
		rdchk(8'h11);
		rdchk(8'h22);
		h.stop();
		$display("t_pin done");
	endtask
	task automatic t_guard();
		apb(1'b1, `SFP_REG_CTRL, 32'h7);
		sc(8'h06);
		cmd(8'h02, 3, 24'h000001);
		h.xfer(8, 8'h00, sb);
		h.stop();
		cmd(8'hd8, 3, 24'h000000);
		h.stop();
		cmd(8'h05, 0, 24'h0);
		rdchk(8'h1e);
		h.stop();
		apb(1'b1, `SFP_REG_CTRL, 32'h0);
		sc(8'h06);
		cmd(8'h02, 3, 24'h000002);
		h.xfer(4, 8'h00, sb);
		h.stop();
		cmd(8'h03, 3, 24'h000001);
		rdchk(8'hff);
		rdchk(8'hff);
		h.stop();
		cmd(8'h90, 3, 24'h000001);
		rdchk(PART);
		rdchk(MAKER);
		h.stop();
		cmd(8'hab, 3, 24'h000000);
		rdchk(MAKER);
		h.stop();
		$display("t_guard done");
	endtask
	task automatic t_block();
		sc(8'h06);
		cmd(8'h52, 3, 24'h007fff);
		h.stop();
		poll();
		cmd(8'h03, 3, 24'h000000);
		rdchk(8'hff);
		h.stop();
		cmd(8'h03, 3, 24'h000010);
		rdchk(8'hff);
		h.stop();
		$display("t_block done");
	endtask
	initial begin
		repeat (4) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		t_regs();
		t_erase();
		t_prog();
		t_word();
		t_pin();
		t_guard();
		t_block();
		test_done();
	end
	// Tests need about 420 us; this cuts a hang short under 100k cycles
	initial begin
		#480000;
		chk(32'h1, 32'h0);
		test_done();
	end
endmodule // tb_top
